/* pkg/cpc_cfg.svh */
// Constants of the compare and PWM timer: register indices, fields, resets.
`ifndef CPC_CFG_SVH
`define CPC_CFG_SVH
// Register indices; the byte address is four times the index.
`define CPC_IDX_CTL 10'h020
`define CPC_IDX_CNTH 10'h021
`define CPC_IDX_CNTL 10'h022
`define CPC_IDX_MODH 10'h023
`define CPC_IDX_MODL 10'h024
`define CPC_IDX_CTL0 10'h025
`define CPC_IDX_CH0H 10'h026
`define CPC_IDX_CH0L 10'h027
`define CPC_IDX_CTL1 10'h028
`define CPC_IDX_CH1H 10'h029
`define CPC_IDX_CH1L 10'h02a
// Field positions shared by the control registers.
`define CPC_B_FLAG 7
`define CPC_B_IE 6
`define CPC_B_HALT 5
`define CPC_B_TRST 4
`define CPC_B_MSH 5
// Reset values, and the prescaler code that selects the pin.
`define CPC_RST_MOD 16'hffff
`define CPC_RST_CTL 7'h00
`define CPC_RST_PS 3'h0
`define CPC_PS_EXT 3'h7
// AXI response codes.
`define CPC_RESP_OKAY 2'h0
`define CPC_RESP_SLVERR 2'h2
`endif

/* pkg/cpc_pkg.sv */
// Types of the compare and PWM timer: state records of each module.
package cpc_pkg;
   // Prescaler divider and pin synchroniser state.
   typedef struct packed {
      logic [5:0] div;
      logic [2:0] sync;
   } cpc_pre_s;
   // Output state of one compare channel.
   typedef struct packed {
      logic pin;
   } cpc_chan_s;
   // Whole state of the timer top.
   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] modv;
      logic [15:0] cmp0;
      logic [15:0] cmp1;
      logic ovf_flag;
      logic ovf_ie;
      logic halt;
      logic [2:0] ps;
      logic mod_inhibit;
      logic ovf_arm;
      logic [6:0] ctl0;
      logic [6:0] ctl1;
      logic flag0;
      logic flag1;
      logic arm0;
      logic arm1;
      logic active_sel;
      logic last_wr;
      logic linked_q;
      logic aw_held;
      logic [9:0] aw_idx;
      logic w_held;
      logic [7:0] wd;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
   } cpc_top_s;
endpackage : cpc_pkg

/* rtl/cpc_prescaler.sv */
// Counter clock enable: bus clock divided by a power of two, or pin edges.
`timescale 1ns/100ps
`include "cpc_cfg.svh"
module cpc_prescaler
   import cpc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic clr,
   input wire logic [2:0] ps,
   input wire logic ext_clk_pin,
   output logic tick
);
   cpc_pre_s s; // Registered state.
   cpc_pre_s n; // Next state.
   logic [5:0] mask; // Low divider bits that must all be set.

   // Divider runs freely; a clear restarts the phase so the first period is whole.
   always_comb begin
      n = s;
      mask = 6'h3f >> (3'h6 - ps);
      if (ps == 3'h0) begin
         mask = 6'h00;
      end
      n.div = clr ? 6'h00 : s.div + 6'h01;
      // Only sync[1] and sync[2] feed logic; sync[0] is the first stage.
      n.sync = {s.sync[1], s.sync[0], ext_clk_pin};
      if (ps == `CPC_PS_EXT) begin
         tick = s.sync[1] & ~s.sync[2];
      end else begin
         tick = ((s.div & mask) == mask);
      end
   end

   // Register the state.
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end
endmodule : cpc_prescaler

/* rtl/cpc_chan_out.sv */
// Pin action of one output compare channel: toggle, clear, set, duty limits.
`timescale 1ns/100ps
`include "cpc_cfg.svh"
module cpc_chan_out
   import cpc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic ovf_ev,
   input wire logic cmp_ev,
   input wire logic [1:0] els,
   input wire logic tov,
   input wire logic full_duty,
   output logic pin_out,
   output logic pin_oe
);
   cpc_chan_s s; // Registered pin level.
   cpc_chan_s n; // Next pin level.

   // Overflow toggles first so a same-edge compare has the final word.
   always_comb begin
      n = s;
      if (enable && els != 2'h0) begin
         if (tov && ovf_ev) begin
            n.pin = ~s.pin;
         end
         if (cmp_ev) begin
            unique case (els)
               2'h1: n.pin = ~n.pin;
               2'h2: n.pin = 1'b0;
               2'h3: n.pin = 1'b1;
               default: n.pin = n.pin;
            endcase
         end
         if (full_duty && tov) begin
            n.pin = ~els[0];
         end
      end
   end

   assign pin_out = s.pin;
   assign pin_oe = enable && (els != 2'h0);

   // Register the pin level.
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end
endmodule : cpc_chan_out

/* rtl/cpc_timer.sv */
// Two-channel 16-bit compare and PWM timer with an AXI4-Lite register slave.
`timescale 1ns/100ps
`include "cpc_cfg.svh"
module cpc_timer
   import cpc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   // AXI4-Lite write address channel.
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data channel.
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response channel.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address channel.
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data channel.
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // System wait mode and external counter clock pin.
   input wire logic wait_mode,
   input wire logic ext_clk_pin,
   // Channel pins.
   output logic channel0_pin_out,
   output logic channel0_pin_oe,
   output logic channel1_pin_out,
   output logic channel1_pin_oe,
   // Interrupt requests and wake request.
   output logic overflow_irq,
   output logic ch0_irq,
   output logic ch1_irq,
   output logic wake_req
);
   cpc_top_s s; // Registered state.
   cpc_top_s n; // Next state.

   logic tick; // Counter clock enable from the prescaler.
   logic run; // Counter advances this cycle.
   logic trst_wr; // Software reset of counter and prescaler.
   logic do_write; // Address and data both held, response free.
   logic ar_take; // Read address accepted this cycle.
   logic [9:0] ar_idx; // Register index of the read.
   logic [15:0] cnt_next; // Counter value after this cycle.
   logic ovf_ev; // Counter wraps this cycle.
   logic linked; // Channels joined into one buffered channel.
   logic [15:0] cmp0_use; // Compare value steering channel 0.
   logic cmp0_ev; // Channel 0 match this cycle.
   logic cmp1_ev; // Channel 1 match this cycle.
   logic out0_en; // Channel 0 in compare or PWM mode.
   logic out1_en; // Channel 1 in compare or PWM mode.
   logic [7:0] rd; // Read data of the addressed register.
   logic rd_hit; // Read index is mapped.

   // Control field aliases for readability.
   // ctl bits: 6 irq enable, 5 mode high, 4 mode low, 3:2 edge, 1 tov, 0 full.
   assign linked = s.ctl0[`CPC_B_MSH];
   // Either mode bit selects output mode on channel 0.
   assign out0_en = s.ctl0[5] | s.ctl0[4];
   // Channel 1 has no high mode bit and is idle while linked.
   assign out1_en = s.ctl1[4] & ~linked;

   // Bus handshakes: each channel is ready while its holding slot is empty.
   assign s_axi_awready = ~s.aw_held;
   assign s_axi_wready = ~s.w_held;
   assign s_axi_arready = ~s.rvalid;
   assign do_write = s.aw_held & s.w_held & ~s.bvalid;
   assign ar_take = s_axi_arvalid & ~s.rvalid;
   assign ar_idx = s_axi_araddr[11:2];

   // A software reset clears the counter and the prescaler phase together.
   assign trst_wr = do_write & s.wstrb0 & ~wait_mode
      & (s.aw_idx == `CPC_IDX_CTL) & s.wd[`CPC_B_TRST];

   // The counter keeps running in wait mode; only the halt bit stops it.
   assign run = tick & ~s.halt;

   // Wrap to zero on the tick after reaching the modulo value.
   assign ovf_ev = run & (s.cnt == s.modv);
   assign cnt_next = ovf_ev ? 16'h0000 : s.cnt + 16'h0001;

   // Linked mode compares against whichever pair is in control.
   assign cmp0_use = (linked && s.active_sel) ? s.cmp1 : s.cmp0;
   // A match is an exact equality with the next count, so the pulse
   // from wrap to match lasts as many ticks as the compare value.
   assign cmp0_ev = run & (cnt_next == cmp0_use);
   assign cmp1_ev = run & (cnt_next == s.cmp1);

   // Read data multiplexer; reserved bits read as zero.
   always_comb begin
      rd = 8'h00;
      rd_hit = 1'b1;
      unique case (ar_idx)
         `CPC_IDX_CTL: rd = {s.ovf_flag, s.ovf_ie, s.halt, 2'b00, s.ps};
         `CPC_IDX_CNTH: rd = s.cnt[15:8];
         `CPC_IDX_CNTL: rd = s.cnt[7:0];
         `CPC_IDX_MODH: rd = s.modv[15:8];
         `CPC_IDX_MODL: rd = s.modv[7:0];
         `CPC_IDX_CTL0: rd = {s.flag0, s.ctl0};
         `CPC_IDX_CH0H: rd = s.cmp0[15:8];
         `CPC_IDX_CH0L: rd = s.cmp0[7:0];
         `CPC_IDX_CTL1: rd = {s.flag1, s.ctl1};
         `CPC_IDX_CH1H: rd = s.cmp1[15:8];
         `CPC_IDX_CH1L: rd = s.cmp1[7:0];
         default: rd_hit = 1'b0;
      endcase
   end

   // Next-state logic: bus writes first, then hardware events, so that an
   // event in the same cycle as a flag clear keeps the flag set, unless that control write also resets the counter.
   always_comb begin
      n = s;

      // Capture write address and data independently, in either order.
      if (s_axi_awvalid && !s.aw_held) begin
         n.aw_held = 1'b1;
         n.aw_idx = s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && !s.w_held) begin
         n.w_held = 1'b1;
         n.wd = s_axi_wdata[7:0];
         n.wstrb0 = s_axi_wstrb[0];
      end
      // The response stays up until the master takes it.
      if (s.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (s.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end

      // Perform a write once both halves are present.
      if (do_write) begin
         n.aw_held = 1'b0;
         n.w_held = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = `CPC_RESP_OKAY;
         if (wait_mode) begin
            // Registers are closed to the processor while waiting.
            n.bresp = `CPC_RESP_SLVERR;
         end else if (s.wstrb0) begin
            unique case (s.aw_idx)
               `CPC_IDX_CTL: begin
                  n.ovf_ie = s.wd[`CPC_B_IE];
                  n.halt = s.wd[`CPC_B_HALT];
                  n.ps = s.wd[2:0];
                  // Writing a one to the flag does nothing.
                  if (!s.wd[`CPC_B_FLAG] && s.ovf_arm) begin
                     n.ovf_flag = 1'b0;
                  end
                  n.ovf_arm = 1'b0;
               end
               `CPC_IDX_CNTH, `CPC_IDX_CNTL: begin
                  // Counter is read-only; writes are accepted and dropped.
                  n.bresp = `CPC_RESP_OKAY;
               end
               `CPC_IDX_MODH: begin
                  n.modv[15:8] = s.wd;
                  n.mod_inhibit = 1'b1;
               end
               `CPC_IDX_MODL: begin
                  n.modv[7:0] = s.wd;
                  n.mod_inhibit = 1'b0;
               end
               `CPC_IDX_CTL0: begin
                  n.ctl0 = s.wd[6:0];
                  if (!s.wd[`CPC_B_FLAG] && s.arm0) begin
                     n.flag0 = 1'b0;
                  end
                  n.arm0 = 1'b0;
               end
               `CPC_IDX_CH0H: begin
                  // New value takes effect on the next compare, or at the next wrap if linked with pair 1 in control.
                  n.cmp0[15:8] = s.wd;
                  n.last_wr = 1'b0;
               end
               `CPC_IDX_CH0L: begin
                  n.cmp0[7:0] = s.wd;
                  n.last_wr = 1'b0;
               end
               `CPC_IDX_CTL1: begin
                  // Channel 1 control is ignored while linked.
                  if (!linked) begin
                     n.ctl1 = s.wd[6:0] & 7'h5f;
                     if (!s.wd[`CPC_B_FLAG] && s.arm1) begin
                        n.flag1 = 1'b0;
                     end
                     n.arm1 = 1'b0;
                  end
               end
               `CPC_IDX_CH1H: begin
                  n.cmp1[15:8] = s.wd;
                  n.last_wr = 1'b1;
               end
               `CPC_IDX_CH1L: begin
                  n.cmp1[7:0] = s.wd;
                  n.last_wr = 1'b1;
               end
               default: n.bresp = `CPC_RESP_SLVERR;
            endcase
         end
      end

      // Accept a read; a control read with its flag set arms the clear, except channel 1 while linked.
      if (ar_take) begin
         n.rvalid = 1'b1;
         n.rdata = 8'h00;
         n.rresp = `CPC_RESP_SLVERR;
         if (!wait_mode && rd_hit) begin
            n.rdata = rd;
            n.rresp = `CPC_RESP_OKAY;
            if (ar_idx == `CPC_IDX_CTL && s.ovf_flag) begin
               n.ovf_arm = 1'b1;
            end
            if (ar_idx == `CPC_IDX_CTL0 && s.flag0) begin
               n.arm0 = 1'b1;
            end
            if (ar_idx == `CPC_IDX_CTL1 && s.flag1 && !linked) begin
               n.arm1 = 1'b1;
            end
         end
      end

      // Counter: software reset wins, otherwise count on each enabled tick.
      if (trst_wr) begin
         n.cnt = 16'h0000;
      end else if (run) begin
         n.cnt = cnt_next;
      end

      // Overflow flag; a pending high-byte modulo write holds it off.
      // A new event also disarms any half-done clear sequence.
      if (ovf_ev && !s.mod_inhibit && !trst_wr) begin
         n.ovf_flag = 1'b1;
         n.ovf_arm = 1'b0;
      end

      // Channel flags follow compare events in output mode.
      if (cmp0_ev && out0_en && !trst_wr) begin
         n.flag0 = 1'b1;
         n.arm0 = 1'b0;
      end
      if (cmp1_ev && out1_en && !trst_wr) begin
         n.flag1 = 1'b1;
         n.arm1 = 1'b0;
      end

      // Buffered hand-over: at each wrap the last written pair takes over.
      if (ovf_ev && linked && !trst_wr) begin
         n.active_sel = n.last_wr;
      end

      // Any change of the link bit restarts from the channel 0 pair.
      n.linked_q = linked;
      if (linked != s.linked_q) begin
         n.active_sel = 1'b0;
         n.last_wr = 1'b0;
      end
   end

   // Single register stage for the whole top state.
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
         s.modv <= `CPC_RST_MOD;
         s.halt <= 1'b1;
         s.ps <= `CPC_RST_PS;
         s.ctl0 <= `CPC_RST_CTL;
         s.ctl1 <= `CPC_RST_CTL;
      end else begin
         s <= n;
      end
   end

   // Counter clock source; the pin is synchronised inside.
   cpc_prescaler u_pre (
      .clk(clk),
      .rst(rst),
      .clr(trst_wr),
      .ps(s.ps),
      .ext_clk_pin(ext_clk_pin),
      .tick(tick)
   );

   // Channel 0 output: plain or linked, always on channel 0 pin.
   cpc_chan_out u_ch0 (
      .clk(clk),
      .rst(rst),
      .enable(out0_en),
      .ovf_ev(ovf_ev & ~trst_wr),
      .cmp_ev(cmp0_ev & ~trst_wr),
      .els(s.ctl0[3:2]),
      .tov(s.ctl0[1]),
      .full_duty(s.ctl0[0]),
      .pin_out(channel0_pin_out),
      .pin_oe(channel0_pin_oe)
   );

   // Channel 1 output; released to the port while linked.
   cpc_chan_out u_ch1 (
      .clk(clk),
      .rst(rst),
      .enable(out1_en),
      .ovf_ev(ovf_ev & ~trst_wr),
      .cmp_ev(cmp1_ev & ~trst_wr),
      .els(s.ctl1[3:2]),
      .tov(s.ctl1[1]),
      .full_duty(s.ctl1[0]),
      .pin_out(channel1_pin_out),
      .pin_oe(channel1_pin_oe)
   );

   // Bus outputs straight from registers.
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rresp = s.rresp;
   assign s_axi_rdata = {24'h00_0000, s.rdata};

   // Interrupt requests are levels while flag and enable are both set; channel 1 is masked while linked.
   assign overflow_irq = s.ovf_flag & s.ovf_ie;
   assign ch0_irq = s.flag0 & s.ctl0[6];
   assign ch1_irq = s.flag1 & s.ctl1[6] & ~linked;
   // Any enabled request wakes the system out of wait mode.
   assign wake_req = wait_mode & (overflow_irq | ch0_irq | ch1_irq);
endmodule : cpc_timer

/* testbench/cpc_timer_asserts.sv */
// Port checker of the compare and PWM timer, bound into the timer top.
`timescale 1ns/100ps
`include "cpc_cfg.svh"
module cpc_timer_asserts (
   input wire logic clk,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic wait_mode,
   input wire logic channel0_pin_oe,
   input wire logic overflow_irq,
   input wire logic ch0_irq,
   input wire logic ch1_irq,
   input wire logic wake_req
);
   // One clock domain, so one default clock and one reset for every check.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Any request line seen by the wake logic.
   logic any_irq;
   assign any_irq = overflow_irq || ch0_irq || ch1_irq;
   a_wake_follows: assert property (wake_req == (wait_mode && any_irq))
      else $error("Wake request disagrees with wait mode and requests.");
   a_wait_refuse: assert property (wait_mode && s_axi_arvalid && s_axi_arready |=>
      s_axi_rresp == `CPC_RESP_SLVERR)
      else $error("Register read in wait mode was not refused.");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("Write response late.");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read response late.");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped before taken.");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data dropped before taken.");
   // Flags clear only through a register write, which shows as a new write response.
   a_chan_irq_drop: assert property ($fell(ch0_irq) |-> $rose(s_axi_bvalid))
      else $error("Channel request fell without a write.");
   a_ovf_irq_drop: assert property ($fell(overflow_irq) |-> $rose(s_axi_bvalid))
      else $error("Overflow request fell without a write.");
   a_oe_by_write: assert property ($changed(channel0_pin_oe) |-> $rose(s_axi_bvalid))
      else $error("Pin enable moved without a control write.");
endmodule : cpc_timer_asserts
bind cpc_timer cpc_timer_asserts i_cpc_timer_asserts (.clk(clk), .rst(rst),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .wait_mode(wait_mode), .channel0_pin_oe(channel0_pin_oe),
   .overflow_irq(overflow_irq), .ch0_irq(ch0_irq), .ch1_irq(ch1_irq), .wake_req(wake_req));

/* testbench/cpc_load.sv */
// External load on a channel pin: pulled down and sampled every clock.
`timescale 1ns/100ps
module cpc_load (
   input wire logic clk,
   input wire logic clr,
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic [15:0] hi_cnt
);
   // The pull-down wins when the pin is released, so a lost enable reads low.
   logic line;
   assign line = pin_oe ? pin_out : 1'b0;
   // Count high cycles since the last clear; the bench reads it as a duty figure.
   always_ff @(posedge clk) begin
      if (clr) begin
         hi_cnt <= 16'h0000;
      end else if (line) begin
         hi_cnt <= hi_cnt + 16'h0001;
      end
   end
endmodule : cpc_load

/* testbench/cpc_timer_tb_top.sv */
// Self-checking bench of the compare and PWM timer.
`timescale 1ns/100ps
`include "cpc_cfg.svh"
module cpc_timer_tb_top;
   logic clk, rst, ld_clr;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic wait_mode, ext_clk_pin, channel0_pin_out, channel0_pin_oe;
   logic channel1_pin_out, channel1_pin_oe, overflow_irq, ch0_irq, ch1_irq, wake_req;
   logic [15:0] hi_cnt, rv;
   logic [2:0] irq_v;
   int err_total, checks_done;
   assign irq_v = {overflow_irq, ch1_irq, ch0_irq};
   cpc_timer i_cpc_timer (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .wait_mode(wait_mode), .ext_clk_pin(ext_clk_pin),
      .channel0_pin_out(channel0_pin_out), .channel0_pin_oe(channel0_pin_oe),
      .channel1_pin_out(channel1_pin_out), .channel1_pin_oe(channel1_pin_oe),
      .overflow_irq(overflow_irq), .ch0_irq(ch0_irq), .ch1_irq(ch1_irq),
      .wake_req(wake_req));
   cpc_load i_cpc_load (.clk(clk), .clr(ld_clr), .pin_out(channel0_pin_out),
      .pin_oe(channel0_pin_oe), .hi_cnt(hi_cnt));
   // Free-running 10 MHz clock.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic print_verdict();
      $display("Checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         err_total++;
      end
   endtask : chk
   // A wait that runs out counts as a mismatch and ends the run.
   task automatic hang(input string nm);
      $display("MISMATCH %s expected answer seen timeout", nm);
      err_total++;
      print_verdict();
   endtask : hang
   // Write one byte register; bready rises only once the answer shows.
   task automatic wr(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] r);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_wvalid <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_bvalid && s_axi_bready) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            return;
         end
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) s_axi_bready <= 1'b1;
      end
      hang("write");
   endtask : wr
   task automatic rd(input logic [9:0] idx, output logic [15:0] d, output logic [1:0] r);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_rvalid && s_axi_rready) begin
            d = {8'h00, s_axi_rdata[7:0]};
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            return;
         end
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) s_axi_rready <= 1'b1;
      end
      hang("read");
   endtask : rd
   task automatic wait_bit(input int b, input string nm);
      for (int n = 0; n < 600; n++) begin
         @(posedge clk);
         if (irq_v[b] === 1'b1) return;
      end
      hang(nm);
   endtask : wait_bit
   // Let two periods pass so an unsynchronised change settles, then count high
   // cycles over exactly one 256-cycle period.
   task automatic duty(input string nm, input logic [15:0] exp);
      repeat (520) @(posedge clk);
      ld_clr <= 1'b1;
      @(posedge clk);
      ld_clr <= 1'b0;
      repeat (257) @(posedge clk);
      chk(nm, exp, hi_cnt);
   endtask : duty
   task automatic t_reset();
      rd(`CPC_IDX_CTL, rv, rs);
      chk("status reset", 16'h0020, rv);
      rd(`CPC_IDX_MODL, rv, rs);
      chk("modulo reset", 16'h00ff, rv);
      rd(10'h000, rv, rs);
      chk("unmapped code", {14'h0000, `CPC_RESP_SLVERR}, {14'h0000, rs});
      chk("unmapped data", 16'h0000, rv);
      $display("Test reset done");
   endtask : t_reset
   task automatic t_pwm();
      wr(`CPC_IDX_CTL, 8'h30, rs);
      wr(`CPC_IDX_MODH, 8'h00, rs);
      wr(`CPC_IDX_MODL, 8'hff, rs);
      wr(`CPC_IDX_CH0H, 8'h00, rs);
      wr(`CPC_IDX_CH0L, 8'h80, rs);
      wr(`CPC_IDX_CTL0, 8'h1a, rs);
      wr(`CPC_IDX_CTL, 8'h00, rs);
      duty("half duty", 16'h0080);
      wr(`CPC_IDX_CH0L, 8'h40, rs);
      wr(`CPC_IDX_CTL0, 8'h1e, rs);
      duty("active low", 16'h00c0);
      wr(`CPC_IDX_CTL0, 8'h18, rs);
      duty("zero duty", 16'h0000);
      wr(`CPC_IDX_CTL0, 8'h1b, rs);
      duty("full duty", 16'h0100);
      $display("Test pwm done");
   endtask : t_pwm
   // Clear sequences run with the counter halted, so no event can fall between the steps.
   task automatic t_irq();
      wr(`CPC_IDX_CTL, 8'h20, rs);
      wr(`CPC_IDX_CTL0, 8'h5a, rs);
      rd(`CPC_IDX_CTL0, rv, rs);
      chk("channel flag", 16'h00da, rv);
      wr(`CPC_IDX_CTL0, 8'h5a, rs);
      chk("channel clear", 16'h0000, {15'h0000, ch0_irq});
      wr(`CPC_IDX_CTL, 8'h40, rs);
      wait_bit(0, "channel request");
      wait_bit(2, "overflow request");
      wr(`CPC_IDX_CTL, 8'h60, rs);
      wait_mode <= 1'b1;
      rd(`CPC_IDX_CTL, rv, rs);
      chk("wait refusal", {14'h0000, `CPC_RESP_SLVERR}, {14'h0000, rs});
      chk("wake", 16'h0001, {15'h0000, wake_req});
      wait_mode <= 1'b0;
      rd(`CPC_IDX_CTL, rv, rs);
      wr(`CPC_IDX_CTL, 8'h60, rs);
      wr(`CPC_IDX_MODH, 8'h00, rs);
      wr(`CPC_IDX_CTL, 8'h40, rs);
      repeat (300) @(posedge clk);
      chk("modulo inhibit", 16'h0000, {15'h0000, overflow_irq});
      wr(`CPC_IDX_MODL, 8'hff, rs);
      wait_bit(2, "overflow resumes");
      $display("Test irq done");
   endtask : t_irq
   // Pair 1 is written last before the link, so only the link change can restart at pair 0.
   // Once linked, software keeps to the inactive pair, as the linked mode expects.
   task automatic t_link();
      wr(`CPC_IDX_CH1H, 8'h00, rs);
      wr(`CPC_IDX_CH1L, 8'h20, rs);
      wr(`CPC_IDX_CTL1, 8'h5b, rs);
      chk("pin 1 driven", 16'h0003, {14'h0000, channel1_pin_oe, channel1_pin_out});
      wait_bit(1, "channel 1 request");
      wr(`CPC_IDX_CTL0, 8'h3a, rs);
      chk("pin 1 released", 16'h0000, {15'h0000, channel1_pin_oe});
      chk("pin 1 request", 16'h0000, {15'h0000, ch1_irq});
      wr(`CPC_IDX_CTL1, 8'h5a, rs);
      rd(`CPC_IDX_CTL1, rv, rs);
      chk("pin 1 control", 16'h00db, rv);
      duty("pair 0 first", 16'h0040);
      wr(`CPC_IDX_CH1L, 8'h20, rs);
      duty("pair 1", 16'h0020);
      wr(`CPC_IDX_CH0L, 8'h90, rs);
      duty("pair 0 again", 16'h0090);
      $display("Test link done");
   endtask : t_link
   // Main sequence: everything starts driven, reset is held for six clocks.
   initial begin
      rst = 1'b1;
      ld_clr = 1'b0;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'h1;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      wait_mode = 1'b0;
      ext_clk_pin = 1'b0;
      err_total = 0;
      checks_done = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_pwm();
      t_irq();
      t_link();
      print_verdict();
   end
endmodule : cpc_timer_tb_top
